//--- src/alert_limit_pkg.sv
// alert threshold constants: register indexes, reset values, field positions
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
//
// Summary of operation
// - bus high threshold is a 15-bit field in bits 14..0 resetting to all ones.
// - both bus thresholds are unsigned 3.125 mV codes compared with the bus result.
// - bus low threshold is a 15-bit field in bits 14..0 resetting to zero.
// - bit 15 of both bus threshold registers always reads zero.
// - temperature limit is a 12-bit signed field in bits 15..4 resetting to 7FFh.
// - an over-temperature is flagged when the die temperature result exceeds the limit.
// - bits 3..0 of the temperature limit register always read zero.
// - power limit is a 16-bit unsigned field resetting to FFFFh, compared with power.
// - the power limit is weighted 256 power result steps, 61.44 mW per step.
// - the maker identification register is a fixed read-only value; writes do nothing.
// - crossings set diagnostic flags in bits 7, 4, 3 and 2.
// - transparent mode follows the fault; latched mode holds flags until diag is read.
package alert_limit_pkg;
  // ------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_BUS_HIGH = 6'h0E;
  localparam logic [5:0] IDX_BUS_LOW = 6'h0F;
  localparam logic [5:0] IDX_TEMP_HIGH = 6'h10;
  localparam logic [5:0] IDX_POWER_HIGH = 6'h11;
  localparam logic [5:0] IDX_MAKER_ID = 6'h3E;
  localparam logic [5:0] IDX_DIAG = 6'h0B;
  localparam logic [5:0] IDX_ALERT_CFG = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h21;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h22;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h23;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [14:0] BUS_HIGH_RST = 15'h7FFF;
  localparam logic [14:0] BUS_LOW_RST = 15'h0000;
  localparam logic [11:0] TEMP_HIGH_RST = 12'h7FF;
  localparam logic [15:0] POWER_HIGH_RST = 16'hFFFF;
  // arbitrary neutral identification value
  localparam logic [15:0] MAKER_CODE = 16'h4E41;

  // ------------------------------------------------------------
  // field positions and channels
  // ------------------------------------------------------------
  localparam int TEMP_LSB = 4;
  localparam int POWER_SHIFT = 8;
  localparam int LATCH_BIT = 15;
  localparam int CH_N = 4;
  localparam int CH_TEMP = 0;
  localparam int CH_BUS_HIGH = 1;
  localparam int CH_BUS_LOW = 2;
  localparam int CH_POWER = 3;
  localparam int FLAG_TEMP_BIT = 7;
  localparam int FLAG_BUS_HIGH_BIT = 4;
  localparam int FLAG_BUS_LOW_BIT = 3;
  localparam int FLAG_POWER_BIT = 2;
  localparam logic [7:0] FLAG_MASK = 8'h9C;
endpackage

//--- src/threshold_flag.sv
// one alarm flag: set on a crossing, cleared by fault removal or a read
// assumes update_i is a one-cycle pulse per new measurement result
`timescale 1ns/1ps
`default_nettype none
module threshold_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic update_i,
  input wire logic crossed_i,
  input wire logic latched_i,
  input wire logic read_clear_i,
  output var logic flag_o,
  output logic set_o
);
  assign set_o = update_i && crossed_i;

  // ------------------------------------------------------------
  // flag state
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_o) begin
      flag_o <= 1'b1;
    end else if (!latched_i && update_i) begin
      flag_o <= 1'b0;
    end else if (latched_i && read_clear_i) begin
      flag_o <= 1'b0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_flag_set_wins: assert property (set_o |=> flag_o)
    else $error("flag not set after crossing");
  chk_latched_hold: assert property (
    latched_i && flag_o && !read_clear_i |=> flag_o)
    else $error("latched flag dropped without read");
  chk_transparent_drop: assert property (
    !latched_i && update_i && !crossed_i |=> !flag_o)
    else $error("transparent flag kept after fault gone");
endmodule
`default_nettype wire

//--- src/alert_limit_thresholds.sv
// alarm threshold register bank with comparators, flags and interrupt
// assumes avalon-mm byte addresses and one-cycle result valid pulses
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module alert_limit_thresholds (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output var logic [31:0] avs_readdata_o,
  output var logic avs_waitrequest_o,
  input wire logic [15:0] bus_voltage_result_i,
  input wire logic bus_result_valid_i,
  input wire logic [15:0] die_temperature_result_i,
  input wire logic temp_result_valid_i,
  input wire logic [23:0] power_result_i,
  input wire logic power_result_valid_i,
  output var logic alert_o,
  output var logic irq_o
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [14:0] bus_high_threshold_r;
  logic [14:0] bus_low_threshold_r;
  logic [11:0] temperature_high_threshold_r;
  logic [15:0] power_high_threshold_r;
  logic alert_latch_select_r;
  logic [7:0] irq_enable_r;
  logic [7:0] irq_status_r;
  logic [7:0] irq_status_nxt;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic [5:0] idx;
  logic req;
  logic acc;
  logic wr;
  logic rd;
  logic lo_en;
  logic hi_en;

  assign idx = avs_address_i[7:2];
  assign req = avs_read_i || avs_write_i;
  // a request completes on the edge where waitrequest is seen low
  assign acc = req && !avs_waitrequest_o;
  assign wr = avs_write_i && acc;
  assign rd = avs_read_i && acc;
  assign lo_en = avs_byteenable_i[0];
  assign hi_en = avs_byteenable_i[1];

  // one wait state per access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // channel comparisons
  // ------------------------------------------------------------
  localparam int CH_N_W = alert_limit_pkg::CH_N;
  logic [CH_N_W-1:0] upd;
  logic [CH_N_W-1:0] crossed;
  logic [CH_N_W-1:0] flag;
  logic [CH_N_W-1:0] set_ev;
  logic diag_read;

  always_comb begin
    upd = '0;
    crossed = '0;
    upd[alert_limit_pkg::CH_TEMP] = temp_result_valid_i;
    upd[alert_limit_pkg::CH_BUS_HIGH] = bus_result_valid_i;
    upd[alert_limit_pkg::CH_BUS_LOW] = bus_result_valid_i;
    upd[alert_limit_pkg::CH_POWER] = power_result_valid_i;
    // signed compare against the limit placed in bits 15..4
    crossed[alert_limit_pkg::CH_TEMP] = $signed(die_temperature_result_i) >
      $signed({temperature_high_threshold_r, 4'h0});
    // unsigned 3.125 mV codes on both sides
    crossed[alert_limit_pkg::CH_BUS_HIGH] =
      bus_voltage_result_i > {1'b0, bus_high_threshold_r};
    crossed[alert_limit_pkg::CH_BUS_LOW] =
      bus_voltage_result_i < {1'b0, bus_low_threshold_r};
    // limit step is 256 power result steps
    crossed[alert_limit_pkg::CH_POWER] =
      power_result_i > {power_high_threshold_r, 8'h00};
  end

  assign diag_read = rd && (idx == alert_limit_pkg::IDX_DIAG);

  genvar g;
  generate
    for (g = 0; g < CH_N_W; g = g + 1) begin : gen_ch
      threshold_flag u_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .update_i(upd[g]),
        .crossed_i(crossed[g]),
        .latched_i(alert_latch_select_r),
        .read_clear_i(diag_read),
        .flag_o(flag[g]),
        .set_o(set_ev[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // diagnostic and event layout
  // ------------------------------------------------------------
  logic [7:0] diag_bits;
  logic [7:0] event_bits;

  always_comb begin
    diag_bits = 8'h00;
    event_bits = 8'h00;
    diag_bits[alert_limit_pkg::FLAG_TEMP_BIT] = flag[alert_limit_pkg::CH_TEMP];
    diag_bits[alert_limit_pkg::FLAG_BUS_HIGH_BIT] = flag[alert_limit_pkg::CH_BUS_HIGH];
    diag_bits[alert_limit_pkg::FLAG_BUS_LOW_BIT] = flag[alert_limit_pkg::CH_BUS_LOW];
    diag_bits[alert_limit_pkg::FLAG_POWER_BIT] = flag[alert_limit_pkg::CH_POWER];
    event_bits[alert_limit_pkg::FLAG_TEMP_BIT] = set_ev[alert_limit_pkg::CH_TEMP];
    event_bits[alert_limit_pkg::FLAG_BUS_HIGH_BIT] = set_ev[alert_limit_pkg::CH_BUS_HIGH];
    event_bits[alert_limit_pkg::FLAG_BUS_LOW_BIT] = set_ev[alert_limit_pkg::CH_BUS_LOW];
    event_bits[alert_limit_pkg::FLAG_POWER_BIT] = set_ev[alert_limit_pkg::CH_POWER];
  end

  // ------------------------------------------------------------
  // threshold writes
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_high_threshold_r <= alert_limit_pkg::BUS_HIGH_RST;
    end else if (wr && idx == alert_limit_pkg::IDX_BUS_HIGH) begin
      if (lo_en) begin
        bus_high_threshold_r[7:0] <= avs_writedata_i[7:0];
      end
      if (hi_en) begin
        bus_high_threshold_r[14:8] <= avs_writedata_i[14:8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_low_threshold_r <= alert_limit_pkg::BUS_LOW_RST;
    end else if (wr && idx == alert_limit_pkg::IDX_BUS_LOW) begin
      if (lo_en) begin
        bus_low_threshold_r[7:0] <= avs_writedata_i[7:0];
      end
      if (hi_en) begin
        bus_low_threshold_r[14:8] <= avs_writedata_i[14:8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      temperature_high_threshold_r <= alert_limit_pkg::TEMP_HIGH_RST;
    end else if (wr && idx == alert_limit_pkg::IDX_TEMP_HIGH) begin
      if (lo_en) begin
        temperature_high_threshold_r[3:0] <= avs_writedata_i[7:4];
      end
      if (hi_en) begin
        temperature_high_threshold_r[11:4] <= avs_writedata_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_high_threshold_r <= alert_limit_pkg::POWER_HIGH_RST;
    end else if (wr && idx == alert_limit_pkg::IDX_POWER_HIGH) begin
      if (lo_en) begin
        power_high_threshold_r[7:0] <= avs_writedata_i[7:0];
      end
      if (hi_en) begin
        power_high_threshold_r[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // alert mode and interrupt control
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_latch_select_r <= 1'b0;
    end else if (wr && hi_en && idx == alert_limit_pkg::IDX_ALERT_CFG) begin
      alert_latch_select_r <= avs_writedata_i[alert_limit_pkg::LATCH_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable_r <= 8'h00;
    end else if (wr && lo_en && idx == alert_limit_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_r <= avs_writedata_i[7:0] & alert_limit_pkg::FLAG_MASK;
    end
  end

  // new events win over a clear in the same cycle
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr && lo_en && idx == alert_limit_pkg::IDX_IRQ_CLEAR) begin
      irq_status_nxt = irq_status_nxt & ~avs_writedata_i[7:0];
    end
    irq_status_nxt = irq_status_nxt | event_bits;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_r <= 8'h00;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_enable_r);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_o <= 1'b0;
    end else begin
      alert_o <= |flag;
    end
  end

  // ------------------------------------------------------------
  // read data, captured on the wait cycle
  // ------------------------------------------------------------
  logic [15:0] rd_word;

  always_comb begin
    if (idx == alert_limit_pkg::IDX_BUS_HIGH) begin
      rd_word = {1'b0, bus_high_threshold_r};
    end else if (idx == alert_limit_pkg::IDX_BUS_LOW) begin
      rd_word = {1'b0, bus_low_threshold_r};
    end else if (idx == alert_limit_pkg::IDX_TEMP_HIGH) begin
      rd_word = {temperature_high_threshold_r, 4'h0};
    end else if (idx == alert_limit_pkg::IDX_POWER_HIGH) begin
      rd_word = power_high_threshold_r;
    end else if (idx == alert_limit_pkg::IDX_MAKER_ID) begin
      rd_word = alert_limit_pkg::MAKER_CODE;
    end else if (idx == alert_limit_pkg::IDX_DIAG) begin
      rd_word = {8'h00, diag_bits};
    end else if (idx == alert_limit_pkg::IDX_ALERT_CFG) begin
      rd_word = {alert_latch_select_r, 15'h0000};
    end else if (idx == alert_limit_pkg::IDX_IRQ_STATUS) begin
      rd_word = {8'h00, irq_status_r};
    end else if (idx == alert_limit_pkg::IDX_IRQ_ENABLE) begin
      rd_word = {8'h00, irq_enable_r};
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {16'h0000, rd_word};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bus_high_write: assert property (
    wr && idx == alert_limit_pkg::IDX_BUS_HIGH && avs_byteenable_i[1:0] == 2'h3
    |=> bus_high_threshold_r == $past(avs_writedata_i[14:0]))
    else $error("bus high threshold write lost");

  chk_bus_low_write: assert property (
    wr && idx == alert_limit_pkg::IDX_BUS_LOW && avs_byteenable_i[1:0] == 2'h3
    |=> bus_low_threshold_r == $past(avs_writedata_i[14:0]))
    else $error("bus low threshold write lost");

  chk_bus_reserved: assert property (
    avs_read_i && avs_waitrequest_o &&
    (idx == alert_limit_pkg::IDX_BUS_HIGH || idx == alert_limit_pkg::IDX_BUS_LOW)
    |=> avs_readdata_o[15] == 1'b0 && !avs_waitrequest_o)
    else $error("bus threshold bit 15 read nonzero");

  chk_temp_reserved: assert property (
    avs_read_i && avs_waitrequest_o && idx == alert_limit_pkg::IDX_TEMP_HIGH
    |=> avs_readdata_o[15:0] == {temperature_high_threshold_r, 4'h0})
    else $error("temperature limit read wrong");

  chk_maker_fixed: assert property (
    avs_read_i && avs_waitrequest_o && idx == alert_limit_pkg::IDX_MAKER_ID
    |=> avs_readdata_o[15:0] == alert_limit_pkg::MAKER_CODE)
    else $error("maker code read wrong");

  chk_temp_trip: assert property (
    temp_result_valid_i && crossed[alert_limit_pkg::CH_TEMP]
    |=> flag[alert_limit_pkg::CH_TEMP] ##1 alert_o)
    else $error("over-temperature not flagged");

  chk_power_scale: assert property (
    power_result_valid_i && power_result_i[23:8] > power_high_threshold_r
    |=> flag[alert_limit_pkg::CH_POWER])
    else $error("power over-limit not flagged");

  chk_bus_low_trip: assert property (
    bus_result_valid_i && bus_voltage_result_i < {1'b0, bus_low_threshold_r}
    |=> irq_status_r[alert_limit_pkg::FLAG_BUS_LOW_BIT])
    else $error("bus low event not recorded");

  chk_latched_read: assert property (
    diag_read && alert_latch_select_r && !(|set_ev) |=> flag == '0)
    else $error("latched flags survive diag read");

  chk_irq_follow: assert property (
    |(irq_status_r & irq_enable_r) |=> irq_o)
    else $error("interrupt not raised");

  chk_one_wait: assert property (
    req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("wait state count wrong");

  chk_bus_high_trip: assert property (
    bus_result_valid_i && bus_voltage_result_i > {1'b0, bus_high_threshold_r}
    |=> flag[alert_limit_pkg::CH_BUS_HIGH])
    else $error("bus over-limit not flagged");

  chk_irq_set_wins: assert property (
    |event_bits |=> (irq_status_r & $past(event_bits)) == $past(event_bits))
    else $error("status event lost");

endmodule
`default_nettype wire

//--- tb/avalon_host_model.sv
// host controller model: avalon-mm master reaching the threshold registers
// assumes waitrequest is sampled at rising edges; read data taken at that edge
`timescale 1ns/1ps
`default_nettype none
module avalon_host_model (
  input wire logic clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [7:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h0;
  end

  // ------------------------------------------------------------
  // one access; released bus shows inverted values
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] d,
                      input logic [3:0] be, output logic [15:0] q);
    @(posedge clk_i);
    avs_address_o <= {idx, 2'b00};
    avs_read_o <= !wr;
    avs_write_o <= wr;
    avs_writedata_o <= {16'h0000, d};
    avs_byteenable_o <= be;
    // loop until waitrequest is seen low; only the bench watchdog ends a wait that never does
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i[15:0];
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_address_o <= ~avs_address_o;
    avs_writedata_o <= ~avs_writedata_o;
  endtask
endmodule
`default_nettype wire

//--- tb/alert_limit_thresholds_tb.sv
// self-checking bench for the alarm threshold register bank
// assumes a host model on the register bus and the bench as result source
`timescale 1ns/1ps
`default_nettype none
module alert_limit_thresholds_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr;
  logic rd_s, wr_s, wreq, alert, irq;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [15:0] bus_v = 16'h0000;
  logic [15:0] die_t = 16'h0000;
  logic [23:0] pwr = 24'h000000;
  logic b_vld = 1'b0;
  logic t_vld = 1'b0;
  logic p_vld = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;

  always #5 clk_i = ~clk_i;

  avalon_host_model host_u (.clk_i(clk_i), .avs_waitrequest_i(wreq), .avs_readdata_i(rdat),
    .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdat),
    .avs_byteenable_o(be));

  alert_limit_thresholds dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .bus_voltage_result_i(bus_v),
    .bus_result_valid_i(b_vld), .die_temperature_result_i(die_t),
    .temp_result_valid_i(t_vld), .power_result_i(pwr), .power_result_valid_i(p_vld),
    .alert_o(alert), .irq_o(irq));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] b = 4'h3);
    logic [15:0] q;
    host_u.xfer(1'b1, idx, d, b, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    host_u.xfer(1'b0, idx, 16'h0000, 4'h3, q);
    chk(q, exp);
  endtask

  // ch 0 temperature, 1 bus, 2 power; waits until alert has settled
  task automatic pulse(input int ch, input logic [23:0] v);
    @(posedge clk_i);
    if (ch == 0) begin
      die_t <= v[15:0];
      t_vld <= 1'b1;
    end else if (ch == 1) begin
      bus_v <= v[15:0];
      b_vld <= 1'b1;
    end else begin
      pwr <= v;
      p_vld <= 1'b1;
    end
    @(posedge clk_i);
    t_vld <= 1'b0;
    b_vld <= 1'b0;
    p_vld <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset_values;
    rd(alert_limit_pkg::IDX_BUS_HIGH, 16'h7FFF);
    rd(alert_limit_pkg::IDX_BUS_LOW, 16'h0000);
    rd(alert_limit_pkg::IDX_TEMP_HIGH, 16'h7FF0);
    rd(alert_limit_pkg::IDX_POWER_HIGH, 16'hFFFF);
    rd(alert_limit_pkg::IDX_MAKER_ID, alert_limit_pkg::MAKER_CODE);
    rd(6'h05, 16'h0000);
    $display("done: reset values");
  endtask

  task automatic test_write_masks;
    wr(alert_limit_pkg::IDX_BUS_HIGH, 16'hFFFF);
    rd(alert_limit_pkg::IDX_BUS_HIGH, 16'h7FFF);
    wr(alert_limit_pkg::IDX_BUS_HIGH, 16'h00AA, 4'h1);
    rd(alert_limit_pkg::IDX_BUS_HIGH, 16'h7FAA);
    wr(alert_limit_pkg::IDX_BUS_LOW, 16'hFFFF);
    rd(alert_limit_pkg::IDX_BUS_LOW, 16'h7FFF);
    wr(alert_limit_pkg::IDX_TEMP_HIGH, 16'hFFFF);
    rd(alert_limit_pkg::IDX_TEMP_HIGH, 16'hFFF0);
    wr(alert_limit_pkg::IDX_POWER_HIGH, 16'h1234);
    rd(alert_limit_pkg::IDX_POWER_HIGH, 16'h1234);
    wr(alert_limit_pkg::IDX_MAKER_ID, 16'h0000);
    rd(alert_limit_pkg::IDX_MAKER_ID, alert_limit_pkg::MAKER_CODE);
    wr(6'h05, 16'h5555);
    rd(6'h05, 16'h0000);
    $display("done: write masks");
  endtask

  task automatic test_transparent;
    wr(alert_limit_pkg::IDX_BUS_HIGH, 16'h1000);
    wr(alert_limit_pkg::IDX_BUS_LOW, 16'h0800);
    wr(alert_limit_pkg::IDX_TEMP_HIGH, 16'h1000);
    wr(alert_limit_pkg::IDX_POWER_HIGH, 16'h0010);
    pulse(1, 24'h001001);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0010);
    chk({15'h0000, alert}, 16'h0001);
    pulse(1, 24'h001000);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0000);
    pulse(1, 24'h0007FF);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0008);
    pulse(1, 24'h000900);
    pulse(0, 24'h001001);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0080);
    pulse(0, 24'h001000);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0000);
    wr(alert_limit_pkg::IDX_TEMP_HIGH, 16'hFF00);
    pulse(0, 24'h000000);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0080);
    pulse(0, 24'h008000);
    pulse(2, 24'h001001);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0004);
    pulse(2, 24'h001000);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0000);
    chk({15'h0000, alert}, 16'h0000);
    $display("done: transparent flags");
  endtask

  task automatic test_latched;
    wr(alert_limit_pkg::IDX_ALERT_CFG, 16'h8000);
    pulse(1, 24'h002000);
    pulse(1, 24'h000900);
    chk({15'h0000, alert}, 16'h0001);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0010);
    rd(alert_limit_pkg::IDX_DIAG, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, alert}, 16'h0000);
    wr(alert_limit_pkg::IDX_ALERT_CFG, 16'h0000);
    $display("done: latched flags");
  endtask

  task automatic test_irq;
    // earlier scenarios left events in the status register
    wr(alert_limit_pkg::IDX_IRQ_CLEAR, 16'h00FF);
    rd(alert_limit_pkg::IDX_IRQ_STATUS, 16'h0000);
    wr(alert_limit_pkg::IDX_IRQ_ENABLE, 16'h0010);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq}, 16'h0000);
    pulse(1, 24'h002000);
    chk({15'h0000, irq}, 16'h0001);
    wr(alert_limit_pkg::IDX_IRQ_ENABLE, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq}, 16'h0000);
    rd(alert_limit_pkg::IDX_IRQ_STATUS, 16'h0010);
    wr(alert_limit_pkg::IDX_IRQ_CLEAR, 16'h0010);
    rd(alert_limit_pkg::IDX_IRQ_STATUS, 16'h0000);
    wr(alert_limit_pkg::IDX_IRQ_ENABLE, 16'h0010);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq}, 16'h0000);
    $display("done: interrupt");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_write_masks();
    test_transparent();
    test_latched();
    test_irq();
    tally_and_finish();
  end

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
